// ==== verilog/rss_top.v ====
// Regulator start-up sequencer, mode control and reset flag supervisor
`timescale 1ns/1ps
`include "rss_defines.vh"
module rss_top #(
    parameter EN_CYC   = `RSS_CYC(`RSS_T_EN_US),
    parameter SS_CYC   = `RSS_CYC(`RSS_T_SS_US),
    parameter REL_CYC  = `RSS_CYC(`RSS_T_REL_US),
    parameter FILT_CYC = `RSS_CYC(`RSS_T_FILT_US)
) (
    input  wire                  clk_i,
    input  wire                  rst_i,
    // Wishbone slave
    input  wire                  wb_cyc_i,
    input  wire                  wb_stb_i,
    input  wire                  wb_we_i,
    input  wire [7:0]            wb_adr_i,
    input  wire [3:0]            wb_sel_i,
    input  wire [31:0]           wb_dat_i,
    output wire [31:0]           wb_dat_o,
    output wire                  wb_ack_o,
    output wire                  irq_o,
    // Pins and analog comparator results
    input  wire                  enable_i,
    input  wire                  forced_fixed_freq_select_i,
    input  wire                  vout_in_limits_i,
    input  wire                  light_load_i,
    input  wire                  duty_below_min_i,
    input  wire                  off_time_min_i,
    // Power stage control
    output wire                  switching_en_o,
    output wire [`RSS_REF_W-1:0] ref_code_o,
    output wire                  fixed_freq_mode_o,
    output wire                  diode_emul_o,
    output wire                  light_load_mode_o,
    output wire [1:0]            freq_sel_o,
    // Open-drain reset flag
    output wire                  reset_flag_o,
    output wire                  reset_flag_oe_o
);

    localparam SS_DIV  = SS_CYC / `RSS_REF_STEPS;
    localparam STEP_M1 = ((SS_DIV < 1) ? 1 : SS_DIV) - 1;
    localparam [`RSS_CNT_W-1:0] STEP_LAST = STEP_M1[`RSS_CNT_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    reg  [1:0]                state_r;
    reg  [1:0]                state_nxt;
    reg  [`RSS_CTRL_W-1:0]    ctrl_r;
    reg  [`RSS_IRQ_W-1:0]     istat_r;
    reg  [`RSS_IRQ_W-1:0]     istat_nxt;
    reg  [`RSS_IRQ_W-1:0]     imask_r;
    reg  [`RSS_IRQ_W-1:0]     ev_w;
    reg  [`RSS_IRQ_W-1:0]     w1c_w;
    reg                       irq_r;
    reg                       ack_r;
    reg  [31:0]               dat_r;
    reg  [31:0]               rd_w;
    reg  [`RSS_CNT_W-1:0]     pre_r;
    reg  [`RSS_REF_W-1:0]     ref_r;
    reg                       vout_bad_r;
    reg                       vout_bad_nxt;
    reg                       vok_d_r;
    reg                       flag_r;
    reg                       flag_nxt;
    reg                       oe_r;
    reg                       lvl_r;
    reg                       sw_r;
    reg                       fix_r;
    reg                       fix_nxt;
    reg                       diode_r;
    reg                       ll_r;
    reg                       ll_nxt;
    reg  [1:0]                freq_r;
    reg  [1:0]                freq_nxt;
    wire [`RSS_S_W-1:0]       pins_s;
    wire                      en_s;
    wire                      ffs_s;
    wire                      vok_s;
    wire                      ll_s;
    wire                      duty_s;
    wire                      toff_s;
    wire                      dly_done;
    wire                      ss_done;
    wire                      filt_done;
    wire                      rel_done;
    wire                      active;
    wire                      req;
    wire                      wr;
    wire [5:0]                idx;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    rss_sync2 #(
        .W (`RSS_S_W)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({off_time_min_i, duty_below_min_i, light_load_i,
                 vout_in_limits_i, forced_fixed_freq_select_i, enable_i}),
        .q_o   (pins_s)
    );

    assign en_s   = pins_s[`RSS_S_EN] & ctrl_r[`RSS_CTRL_EN];
    assign ffs_s  = pins_s[`RSS_S_FFS];
    assign vok_s  = pins_s[`RSS_S_VOK];
    assign ll_s   = pins_s[`RSS_S_LL];
    assign duty_s = pins_s[`RSS_S_DUTY];
    assign toff_s = pins_s[`RSS_S_TOFF];
    assign active = (state_nxt == `RSS_ST_SOFT) || (state_nxt == `RSS_ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Interval timers
    // Turn-on delay
    rss_timer #(
        .LIMIT (EN_CYC)
    ) u_dly (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (state_r != `RSS_ST_DELAY),
        .run_i  (1'b1),
        .done_o (dly_done)
    );

    rss_timer #(
        .LIMIT (SS_CYC)
    ) u_ss (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (state_r != `RSS_ST_SOFT),
        .run_i  (1'b1),
        .done_o (ss_done)
    );

    rss_timer #(
        .LIMIT (FILT_CYC)
    ) u_filt (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (vok_s || !en_s),
        .run_i  (1'b1),
        .done_o (filt_done)
    );

    rss_timer #(
        .LIMIT (REL_CYC)
    ) u_rel (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (vout_bad_r || state_r == `RSS_ST_OFF),
        .run_i  (1'b1),
        .done_o (rel_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            `RSS_ST_OFF:
                if (en_s)
                    state_nxt = `RSS_ST_DELAY;
            `RSS_ST_DELAY:
                if (!en_s)
                    state_nxt = `RSS_ST_OFF;
                else if (dly_done)
                    state_nxt = `RSS_ST_SOFT;
            `RSS_ST_SOFT:
                if (!en_s)
                    state_nxt = `RSS_ST_OFF;
                else if (ss_done)
                    state_nxt = `RSS_ST_RUN;
            `RSS_ST_RUN:
                if (!en_s)
                    state_nxt = `RSS_ST_OFF;
            default:
                state_nxt = `RSS_ST_OFF;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output supervisor
    always @*
    begin
        vout_bad_nxt = vout_bad_r;
        if (!en_s || state_r == `RSS_ST_OFF)
            vout_bad_nxt = 1'b1;
        else if (filt_done)
            vout_bad_nxt = 1'b1;
        else if (vok_s)
            vout_bad_nxt = 1'b0;
        flag_nxt = rel_done;
        if (vout_bad_r)
            flag_nxt = 1'b0;
        if (!en_s || state_r == `RSS_ST_OFF)
            flag_nxt = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode selection
    always @*
    begin
        fix_nxt = (state_nxt == `RSS_ST_RUN) && ffs_s && !ctrl_r[`RSS_CTRL_AUTO];
        ll_nxt = active && !fix_nxt && ll_s;
        if (!active)
            freq_nxt = `RSS_FQ_NOM;
        else if (toff_s)
            freq_nxt = `RSS_FQ_SPREAD;
        else if (duty_s)
            freq_nxt = `RSS_FQ_FOLD;
        else if (ll_nxt)
            freq_nxt = `RSS_FQ_LIGHT;
        else
            freq_nxt = `RSS_FQ_NOM;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events and bus decode
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr  = req && wb_we_i;
    assign idx = wb_adr_i[7:2];

    always @*
    begin
        ev_w = `RSS_IRQ_NONE;
        ev_w[`RSS_IRQ_REL]    = flag_nxt && !flag_r;
        ev_w[`RSS_IRQ_FAULT]  = flag_r && !flag_nxt;
        ev_w[`RSS_IRQ_GLITCH] = en_s && vok_s && !vok_d_r && !vout_bad_r;
        ev_w[`RSS_IRQ_SSDONE] = (state_r == `RSS_ST_SOFT) && (state_nxt == `RSS_ST_RUN);
        w1c_w = `RSS_IRQ_NONE;
        if (wr && wb_sel_i[0] && idx == `RSS_IX_ISTAT)
            w1c_w = wb_dat_i[`RSS_IRQ_W-1:0];
        // Set wins over clear
        istat_nxt = (istat_r & ~w1c_w) | ev_w;
    end

    always @*
    begin
        rd_w = `RSS_WORD_ZERO;
        case (idx)
            `RSS_IX_CTRL:
                rd_w[`RSS_CTRL_W-1:0] = ctrl_r;
            `RSS_IX_STAT:
            begin
                rd_w[`RSS_STF_STATE+1:`RSS_STF_STATE] = state_r;
                rd_w[`RSS_STF_FLAG]  = flag_r;
                rd_w[`RSS_STF_VOK]   = !vout_bad_r;
                rd_w[`RSS_STF_FIX]   = fix_r;
                rd_w[`RSS_STF_DIODE] = diode_r;
                rd_w[`RSS_STF_FREQ+1:`RSS_STF_FREQ] = freq_r;
                rd_w[`RSS_STF_REF+`RSS_REF_W-1:`RSS_STF_REF] = ref_r;
            end
            `RSS_IX_ISTAT:
                rd_w[`RSS_IRQ_W-1:0] = istat_r;
            `RSS_IX_IMASK:
                rd_w[`RSS_IRQ_W-1:0] = imask_r;
            default:
                rd_w = `RSS_WORD_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r    <= `RSS_ST_OFF;
            ctrl_r     <= `RSS_CTRL_RST;
            istat_r    <= `RSS_IRQ_NONE;
            imask_r    <= `RSS_IRQ_NONE;
            irq_r      <= 1'b0;
            ack_r      <= 1'b0;
            dat_r      <= `RSS_WORD_ZERO;
            pre_r      <= {`RSS_CNT_W{1'b0}};
            ref_r      <= `RSS_REF_ZERO;
            vout_bad_r <= 1'b1;
            vok_d_r    <= 1'b0;
            flag_r     <= 1'b0;
            oe_r       <= 1'b1;
            lvl_r      <= 1'b0;
            sw_r       <= 1'b0;
            fix_r      <= 1'b0;
            diode_r    <= 1'b0;
            ll_r       <= 1'b0;
            freq_r     <= `RSS_FQ_NOM;
        end
        else
        begin
            state_r    <= state_nxt;
            vout_bad_r <= vout_bad_nxt;
            vok_d_r    <= vok_s;
            flag_r     <= flag_nxt;
            oe_r       <= !flag_nxt;
            lvl_r      <= 1'b0;
            sw_r       <= active;
            fix_r      <= fix_nxt;
            diode_r    <= active && ((state_nxt == `RSS_ST_SOFT) || !fix_nxt);
            ll_r       <= ll_nxt;
            freq_r     <= freq_nxt;
            if (state_nxt == `RSS_ST_RUN)
                ref_r <= `RSS_REF_MAX;
            else if (state_nxt != `RSS_ST_SOFT)
                ref_r <= `RSS_REF_ZERO;
            else if (pre_r == STEP_LAST && ref_r != `RSS_REF_MAX)
                ref_r <= ref_r + 1'b1;
            if (state_nxt != `RSS_ST_SOFT || pre_r == STEP_LAST)
                pre_r <= {`RSS_CNT_W{1'b0}};
            else
                pre_r <= pre_r + 1'b1;
            // Bus slave
            ack_r <= req;
            if (req)
                dat_r <= wb_we_i ? `RSS_WORD_ZERO : rd_w;
            if (wr && wb_sel_i[0] && idx == `RSS_IX_CTRL)
                ctrl_r <= wb_dat_i[`RSS_CTRL_W-1:0];
            if (wr && wb_sel_i[0] && idx == `RSS_IX_IMASK)
                imask_r <= wb_dat_i[`RSS_IRQ_W-1:0];
            istat_r <= istat_nxt;
            irq_r   <= |(istat_nxt & imask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_dat_o          = dat_r;
    assign wb_ack_o          = ack_r;
    assign irq_o             = irq_r;
    assign switching_en_o    = sw_r;
    assign ref_code_o        = ref_r;
    assign fixed_freq_mode_o = fix_r;
    assign diode_emul_o      = diode_r;
    assign light_load_mode_o = ll_r;
    assign freq_sel_o        = freq_r;
    assign reset_flag_o      = lvl_r;
    assign reset_flag_oe_o   = oe_r;
endmodule

// ==== shared/rss_defines.vh ====
// Constants for the regulator start-up sequencer and reset flag supervisor
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH

// Clock rate and documented times
`define RSS_CLK_MHZ      200
`define RSS_T_EN_US      1000
`define RSS_T_SS_US      3000
`define RSS_T_REL_US     3000
`define RSS_T_FILT_US    25
`define RSS_CYC(us)      ((us) * `RSS_CLK_MHZ)

// Counter and reference widths
`define RSS_CNT_W        20
`define RSS_REF_W        10
`define RSS_REF_STEPS    1024
`define RSS_REF_MAX      10'h3FF
`define RSS_REF_ZERO     10'h000

// Sequencer states
`define RSS_ST_OFF       2'h0
`define RSS_ST_DELAY     2'h1
`define RSS_ST_SOFT      2'h2
`define RSS_ST_RUN       2'h3

// Switching frequency codes
`define RSS_FQ_NOM       2'h0
`define RSS_FQ_FOLD      2'h1
`define RSS_FQ_SPREAD    2'h2
`define RSS_FQ_LIGHT     2'h3

// Synchronised pin positions
`define RSS_S_EN         0
`define RSS_S_FFS        1
`define RSS_S_VOK        2
`define RSS_S_LL         3
`define RSS_S_DUTY       4
`define RSS_S_TOFF       5
`define RSS_S_W          6

// Register word indices (byte address = 4 * index)
`define RSS_IX_CTRL      6'h00
`define RSS_IX_STAT      6'h01
`define RSS_IX_ISTAT     6'h02
`define RSS_IX_IMASK     6'h03

// Control register
`define RSS_CTRL_EN      0
`define RSS_CTRL_AUTO    1
`define RSS_CTRL_W       2
`define RSS_CTRL_RST     2'h1

// Interrupt bits
`define RSS_IRQ_REL      0
`define RSS_IRQ_FAULT    1
`define RSS_IRQ_GLITCH   2
`define RSS_IRQ_SSDONE   3
`define RSS_IRQ_W        4
`define RSS_IRQ_NONE     4'h0

// Status register fields
`define RSS_STF_STATE    0
`define RSS_STF_FLAG     2
`define RSS_STF_VOK      3
`define RSS_STF_FIX      4
`define RSS_STF_DIODE    5
`define RSS_STF_FREQ     6
`define RSS_STF_REF      16

`define RSS_WORD_ZERO    32'h00000000

`endif

// ==== verilog/rss_sync2.v ====
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module rss_sync2 #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end
        else
        begin
            meta_r <= d_i;
            sync_r <= meta_r;
        end
    end

    assign q_o = sync_r;
endmodule

// ==== verilog/rss_timer.v ====
// Saturating interval timer with clear
`timescale 1ns/1ps
`include "rss_defines.vh"
module rss_timer #(
    parameter LIMIT = 1
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire clr_i,
    input  wire run_i,
    output wire done_o
);
    localparam integer          LIM_I = LIMIT;
    localparam [`RSS_CNT_W-1:0] LIM   = LIM_I[`RSS_CNT_W-1:0];

    reg [`RSS_CNT_W-1:0] cnt_r;

    assign done_o = (cnt_r == LIM);

    always @(posedge clk_i)
    begin
        if (rst_i || clr_i)
            cnt_r <= {`RSS_CNT_W{1'b0}};
        else if (run_i && !done_o)
            cnt_r <= cnt_r + 1'b1;
    end
endmodule

// ==== testbench/rss_top_chk.sv ====
// Port checker for the start-up sequencer and reset flag supervisor
`timescale 1ns/1ps
module rss_top_chk #(
    parameter EN_CYC   = 40,
    parameter SS_CYC   = 2048,
    parameter REL_CYC  = 60,
    parameter FILT_CYC = 8
) (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       wb_cyc_i,
    input  wire       wb_stb_i,
    input  wire       wb_ack_o,
    input  wire       enable_i,
    input  wire       vout_in_limits_i,
    input  wire       switching_en_o,
    input  wire [9:0] ref_code_o,
    input  wire       fixed_freq_mode_o,
    input  wire       diode_emul_o,
    input  wire       light_load_mode_o,
    input  wire [1:0] freq_sel_o,
    input  wire       reset_flag_o,
    input  wire       reset_flag_oe_o
);
    int   en_hi;
    int   en_lo;
    int   sw_n;
    int   dip;
    int   rel;
    logic vok_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Cycle counters
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            en_hi <= 0;
            en_lo <= 0;
            sw_n  <= 0;
            dip   <= 0;
            rel   <= 0;
            vok_q <= 1'b1;
        end
        else
        begin
            en_hi <= enable_i ? en_hi + 1 : 0;
            en_lo <= enable_i ? 0 : en_lo + 1;
            sw_n  <= switching_en_o ? sw_n + 1 : 0;
            vok_q <= vout_in_limits_i;
            dip   <= vout_in_limits_i ? dip : (vok_q ? 1 : dip + 1);
            rel   <= (!enable_i || (!vout_in_limits_i && dip >= FILT_CYC)) ? 0 : rel + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_od;
        reset_flag_o == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("flag value not low");
    property p_flag_dis;
        en_lo >= 6 |-> reset_flag_oe_o && !switching_en_o && ref_code_o == 10'h000;
    endproperty
    a_flag_dis: assert property (p_flag_dis) else $error("disabled but not off");
    property p_delay;
        $rose(switching_en_o) |-> en_hi >= EN_CYC && en_hi <= EN_CYC + 8;
    endproperty
    a_delay: assert property (p_delay) else $error("turn-on delay wrong");
    property p_auto_ss;
        switching_en_o && sw_n < SS_CYC - 4 |-> !fixed_freq_mode_o && diode_emul_o;
    endproperty
    a_auto_ss: assert property (p_auto_ss) else $error("not auto in soft start");
    property p_ramp;
        (sw_n == SS_CYC / 2 |-> ref_code_o > 10'h100 && ref_code_o < 10'h300)
        and (sw_n == SS_CYC + 6 |-> ref_code_o == 10'h3FF);
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp timing wrong");
    property p_fixed;
        fixed_freq_mode_o |-> !diode_emul_o && !light_load_mode_o && freq_sel_o != 2'h3;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed mode not clean");
    property p_light;
        light_load_mode_o |-> diode_emul_o && !fixed_freq_mode_o;
    endproperty
    a_light: assert property (p_light) else $error("light load mode wrong");
    property p_rel;
        $fell(reset_flag_oe_o) |-> rel >= REL_CYC && enable_i;
    endproperty
    a_rel: assert property (p_rel) else $error("flag released early");
    property p_glitch;
        $rose(reset_flag_oe_o) && en_hi > 8 |-> dip >= FILT_CYC;
    endproperty
    a_glitch: assert property (p_glitch) else $error("short dip pulled flag");
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing wrong");
    c_rel: cover property ($fell(reset_flag_oe_o));
    c_trip: cover property ($rose(reset_flag_oe_o) && en_hi > 8);
    c_run: cover property ($rose(fixed_freq_mode_o));
endmodule
bind rss_top rss_top_chk #(
    .EN_CYC   (EN_CYC),
    .SS_CYC   (SS_CYC),
    .REL_CYC  (REL_CYC),
    .FILT_CYC (FILT_CYC)
) i_chk (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .wb_cyc_i          (wb_cyc_i),
    .wb_stb_i          (wb_stb_i),
    .wb_ack_o          (wb_ack_o),
    .enable_i          (enable_i),
    .vout_in_limits_i  (vout_in_limits_i),
    .switching_en_o    (switching_en_o),
    .ref_code_o        (ref_code_o),
    .fixed_freq_mode_o (fixed_freq_mode_o),
    .diode_emul_o      (diode_emul_o),
    .light_load_mode_o (light_load_mode_o),
    .freq_sel_o        (freq_sel_o),
    .reset_flag_o      (reset_flag_o),
    .reset_flag_oe_o   (reset_flag_oe_o)
);

// ==== testbench/rss_host_model.sv ====
// Host side: enable and select pins, pulled-up reset flag consumer
`timescale 1ns/1ps
module rss_host_model (
    input  wire en_req_i,
    input  wire ffs_req_i,
    input  wire flag_oe_i,
    output wire enable_o,
    output wire ffs_o,
    output wire flag_pin_o
);
    assign enable_o = en_req_i;
    assign ffs_o    = ffs_req_i;
    assign flag_pin_o = flag_oe_i ? 1'b0 : 1'b1;
endmodule

// ==== testbench/tb_regulator_startup_and_reset_flag.sv ====
// Self-checking bench for the regulator start-up sequencer
`timescale 1ns/1ps
module tb_regulator_startup_and_reset_flag;
    localparam EN = 40, SS = 2048, REL = 60, FILT = 8;
    logic        clk_i;
    logic        rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h00000000, rd;
    logic        en_req = 1'b0, ffs_req = 1'b0, vok = 1'b0, ll = 1'b0, duty = 1'b0, toff = 1'b0;
    wire  [31:0] rdat;
    wire         ack, irq, enable, ffs, flag_pin, sw, fixed, diode, llm, flag, oe;
    wire  [9:0]  ref_code;
    wire  [1:0]  fsel;
    int          num_errors = 0, compares = 0, n, m;
    rss_top #(.EN_CYC(EN), .SS_CYC(SS), .REL_CYC(REL), .FILT_CYC(FILT)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .enable_i(enable), .forced_fixed_freq_select_i(ffs),
        .vout_in_limits_i(vok), .light_load_i(ll), .duty_below_min_i(duty),
        .off_time_min_i(toff), .switching_en_o(sw), .ref_code_o(ref_code),
        .fixed_freq_mode_o(fixed), .diode_emul_o(diode), .light_load_mode_o(llm),
        .freq_sel_o(fsel), .reset_flag_o(flag), .reset_flag_oe_o(oe));
    rss_host_model i_host (.en_req_i(en_req), .ffs_req_i(ffs_req), .flag_oe_i(oe),
        .enable_o(enable), .ffs_o(ffs), .flag_pin_o(flag_pin));
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc_n(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack !== 1'b1 && k < 50);
        chk(ack, 32'h1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task wait_on(input int s, input logic lvl, input int lim);
        n = 0;
        while ((s == 0 ? sw : s == 1 ? oe : fixed) !== lvl && n < lim)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task dip(input int len);
        vok <= 1'b0;
        cyc_n(len);
        vok <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk({oe, sw}, 32'h2);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h1);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask
    task t_start;
        ffs_req <= 1'b1;
        en_req <= 1'b1;
        wait_on(0, 1'b1, 200);
        chk(n >= EN && n <= EN + 8, 32'h1);
        cyc_n(SS / 4);
        chk({fixed, diode}, 32'h1);
        chk(ref_code > 10'h0C0 && ref_code < 10'h140, 32'h1);
        vok <= 1'b1;
        wait_on(1, 1'b0, 200);
        chk(n >= REL && n <= REL + 8, 32'h1);
        m = n;
        wait_on(2, 1'b1, 3000);
        chk(SS / 4 + m + n >= SS && SS / 4 + m + n <= SS + 8, 32'h1);
        chk(ref_code, 32'h3FF);
        $display("test start done");
    endtask
    task t_glitch;
        dip(FILT / 2);
        cyc_n(30);
        chk(oe, 32'h0);
        dip(3 * FILT);
        cyc_n(4);
        chk(oe, 32'h1);
        cyc_n(30);
        dip(3 * FILT);
        wait_on(1, 1'b0, 200);
        chk(n >= REL && n <= REL + 8, 32'h1);
        $display("test glitch done");
    endtask
    task t_irq;
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'hF);
        chk(irq, 32'h0);
        bus(1'b1, 8'h0C, 32'h2);
        cyc_n(2);
        chk(irq, 32'h1);
        bus(1'b1, 8'h08, 32'h2);
        cyc_n(2);
        chk(irq, 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'hD);
        $display("test irq done");
    endtask
    task t_modes;
        ll <= 1'b1;
        cyc_n(6);
        chk({fixed, diode, llm, fsel}, 32'h10);
        ffs_req <= 1'b0;
        cyc_n(6);
        chk({fixed, diode, llm, fsel}, 32'h0F);
        ll <= 1'b0;
        duty <= 1'b1;
        cyc_n(6);
        chk(fsel, 32'h1);
        duty <= 1'b0;
        toff <= 1'b1;
        cyc_n(6);
        chk(fsel, 32'h2);
        toff <= 1'b0;
        ffs_req <= 1'b1;
        bus(1'b1, 8'h00, 32'h3);
        cyc_n(2);
        chk({fixed, diode}, 32'h1);
        bus(1'b1, 8'h00, 32'h1);
        cyc_n(2);
        chk({fixed, diode}, 32'h2);
        $display("test modes done");
    endtask
    task t_off;
        en_req <= 1'b0;
        cyc_n(6);
        chk({flag, oe, sw, flag_pin, ref_code}, 32'h1000);
        bus(1'b1, 8'h00, 32'h0);
        en_req <= 1'b1;
        cyc_n(EN + 20);
        chk({oe, sw, ref_code}, 32'h800);
        $display("test off done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        cyc_n(10);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_start;
        t_glitch;
        t_irq;
        t_modes;
        t_off;
        conclude;
    end
    initial
    begin
        cyc_n(20000);
        num_errors++;
        conclude;
    end
endmodule
